// file: rtl/cfg_access.v
// Configuration register access interpreter: ten banks, status-word port
// and token-framed request/response messages on byte streams.
// Assumes the channel end delivers one token per valid/ready handshake.
// Notes on behaviour
// - Ten register banks, each with own path
// - Status instructions move one whole word
// - Write: 192, return id, reg16, data32, 1
// - Write answer: 3,1 ok or 4,1 fail
// - Read: 193, return id, reg16, 1
// - Read answer: 3, data32, 1 or 4,1
// - Peripheral tokens 36/37, reg8, size8, data
// - Peripheral read: 3, data, 1 or 4,1
`include "cfg_access_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module cfg_access #(
  parameter ADDR_W = 4
) (
  input  wire        clk_sys,
  input  wire        rst_n,
  input  wire [15:0] ps_res_id,
  input  wire        ps_rd,
  input  wire        ps_wr,
  input  wire [31:0] ps_wdata,
  output reg  [31:0] ps_rdata,
  input  wire [3:0]  msg_bank,
  input  wire        in_valid,
  input  wire        in_ctrl,
  input  wire [7:0]  in_data,
  output wire        in_ready,
  output reg         out_valid,
  output reg         out_ctrl,
  output reg  [7:0]  out_data,
  output reg  [23:0] out_dest,
  input  wire        out_ready
);
  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [6:0] S_CMD  = 7'h01;
  localparam [6:0] S_RET  = 7'h02;
  localparam [6:0] S_REG  = 7'h04;
  localparam [6:0] S_SIZE = 7'h08;
  localparam [6:0] S_DATA = 7'h10;
  localparam [6:0] S_END  = 7'h20;
  localparam [6:0] S_RSP  = 7'h40;

  reg  [6:0]  state_ff;
  reg  [6:0]  nxt_state;
  reg  [7:0]  cmd_ff;
  reg  [3:0]  bank_ff;
  reg  [23:0] ret_ff;
  reg  [15:0] reg_ff;
  reg  [7:0]  size_ff;
  reg  [31:0] data_ff;
  reg  [7:0]  cnt_ff;
  reg         bad_ff;
  reg  [2:0]  rsp_idx_ff;
  reg  [2:0]  rsp_len_ff;
  reg         rsp_ok_ff;
  reg         commit_ff;
  wire        take = in_valid & in_ready;
  wire        is_wr = (cmd_ff == `TOK_WRITE) | (cmd_ff == `TOK_PWRITE);
  wire        is_per = (cmd_ff == `TOK_PWRITE) | (cmd_ff == `TOK_PREAD);
  wire [7:0]  reg_top = is_per ? 8'h0 : reg_ff[15:8];
  wire        reg_ok = (reg_top == 8'h0) && (reg_ff[7:0] < (8'h1 << ADDR_W));
  wire [3:0]  data_len = is_per ? ((size_ff > {5'h0, `DATA_BYTES} || size_ff == 8'h0)
                                   ? {1'b0, `DATA_BYTES} : size_ff[3:0])
                                : {1'b0, `DATA_BYTES};

  assign in_ready = (state_ff != S_RSP) & ~commit_ff;

  // ----------------------------------------------------------------
  // Register banks
  // ----------------------------------------------------------------
  wire [31:0]       bank_rd [0:`BANK_COUNT-1];
  wire [ADDR_W-1:0] ps_addr = ps_res_id[`PS_RES_SHIFT +: ADDR_W];
  wire              ps_hit = (ps_res_id[7:0] == `PS_RES_CODE);
  genvar g;
  generate
    for (g = 0; g < `BANK_COUNT; g = g + 1) begin : bank
      wire is_ps = (g == `BANK_PS);
      wire wr = is_ps ? (ps_wr & ps_hit)
                      : (commit_ff & rsp_ok_ff & is_wr & (bank_ff == g));
      cfg_bank #(.ADDR_W(ADDR_W)) u_bank (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .wr_en   (wr),
        .addr    (is_ps ? ps_addr : reg_ff[ADDR_W-1:0]),
        .wdata   (is_ps ? ps_wdata : data_ff),
        .rdata   (bank_rd[g])
      );
    end
  endgenerate

  // Whole-word status read; the bank port lags one edge behind the address
  reg ps_rd_ff;

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      ps_rd_ff <= 1'b0;
      ps_rdata <= 32'h0;
    end else begin
      ps_rd_ff <= ps_rd & ps_hit;
      if (ps_rd_ff) begin
        ps_rdata <= bank_rd[`BANK_PS];
      end
    end
  end

  // ----------------------------------------------------------------
  // Request parser
  // ----------------------------------------------------------------
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      S_CMD:  if (take) nxt_state = S_RET;
      S_RET:  if (take && cnt_ff == {5'h0, `RET_BYTES} - 8'h1) nxt_state = S_REG;
      S_REG:  if (take && cnt_ff == {5'h0, (is_per ? `PREG_BYTES : `WREG_BYTES)} - 8'h1)
                nxt_state = is_per ? S_SIZE : (is_wr ? S_DATA : S_END);
      S_SIZE: if (take) nxt_state = is_wr ? S_DATA : S_END;
      S_DATA: if (take && cnt_ff == {4'h0, data_len} - 8'h1) nxt_state = S_END;
      S_END:  if (take) nxt_state = S_RSP;
      S_RSP:  if (out_valid && out_ready && rsp_idx_ff == rsp_len_ff) nxt_state = S_CMD;
      default: nxt_state = S_CMD;
    endcase
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      state_ff  <= S_CMD;
      cmd_ff    <= 8'h0;
      bank_ff   <= 4'h0;
      ret_ff    <= 24'h0;
      reg_ff    <= 16'h0;
      size_ff   <= 8'h0;
      data_ff   <= 32'h0;
      cnt_ff    <= 8'h0;
      bad_ff    <= 1'b0;
      commit_ff <= 1'b0;
      rsp_ok_ff <= 1'b0;
    end else begin
      state_ff  <= nxt_state;
      commit_ff <= (state_ff == S_END) & take;
      if (take) begin
        cnt_ff <= (nxt_state != state_ff) ? 8'h0 : cnt_ff + 8'h1;
        case (state_ff)
          S_CMD: begin
            cmd_ff  <= in_data;
            bank_ff <= msg_bank;
            reg_ff  <= 16'h0;
            data_ff <= 32'h0;
            size_ff <= 8'h0;
            bad_ff  <= ~in_ctrl | ~((in_data == `TOK_WRITE) | (in_data == `TOK_READ)
                        | (in_data == `TOK_PWRITE) | (in_data == `TOK_PREAD))
                        | (msg_bank == `BANK_PS) | (msg_bank >= `BANK_COUNT);
          end
          S_RET:  begin
            ret_ff <= {ret_ff[15:0], in_data};
            bad_ff <= bad_ff | in_ctrl;
          end
          S_REG:  begin
            reg_ff <= {reg_ff[7:0], in_data};
            bad_ff <= bad_ff | in_ctrl;
          end
          S_SIZE: begin
            size_ff <= in_data;
            bad_ff  <= bad_ff | in_ctrl;
          end
          S_DATA: begin
            data_ff <= {data_ff[23:0], in_data};
            bad_ff  <= bad_ff | in_ctrl;
          end
          S_END:  bad_ff <= bad_ff | ~in_ctrl | (in_data != `TOK_END);
          default: bad_ff <= bad_ff;
        endcase
      end
      if ((state_ff == S_END) & take) begin
        rsp_ok_ff <= ~(bad_ff | ~in_ctrl | (in_data != `TOK_END)) & reg_ok;
      end
      // Read word is loaded here only, so data_ff keeps a single driver
      if (commit_ff & rsp_ok_ff & ~is_wr) begin
        data_ff <= bank_rd[bank_ff];
      end
    end
  end

  // ----------------------------------------------------------------
  // Response generator
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      out_valid  <= 1'b0;
      out_ctrl   <= 1'b0;
      out_data   <= 8'h0;
      out_dest   <= 24'h0;
      rsp_idx_ff <= 3'h0;
      rsp_len_ff <= 3'h0;
    end else if (commit_ff) begin
      out_valid  <= 1'b1;
      out_ctrl   <= 1'b1;
      out_dest   <= ret_ff;
      rsp_idx_ff <= 3'h0;
      out_data   <= rsp_ok_ff ? `TOK_ACK : `TOK_NACK;
      rsp_len_ff <= (rsp_ok_ff & ~is_wr) ? data_len[2:0] + 3'h1 : 3'h1;
    end else if (out_valid && out_ready) begin
      if (rsp_idx_ff == rsp_len_ff) begin
        out_valid <= 1'b0;
      end else begin
        rsp_idx_ff <= rsp_idx_ff + 3'h1;
        if (rsp_idx_ff + 3'h1 == rsp_len_ff) begin
          out_ctrl <= 1'b1;
          out_data <= `TOK_END;
        end else begin
          out_ctrl <= 1'b0;
          out_data <= data_ff[31 - 8*rsp_idx_ff[1:0] -: 8];
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: rtl/cfg_access_consts.vh
// Constants for the configuration register access interpreter.
// Included by the cfg_access module; definitions only.
`ifndef CFG_ACCESS_CONSTS_VH
`define CFG_ACCESS_CONSTS_VH

`define TOK_WRITE        8'hc0
`define TOK_READ         8'hc1
`define TOK_PWRITE       8'h24
`define TOK_PREAD        8'h25
`define TOK_ACK          8'h03
`define TOK_NACK         8'h04
`define TOK_END          8'h01
`define PS_RES_CODE      8'h0c
`define PS_RES_SHIFT     8
`define RET_BYTES        3'h3
`define WREG_BYTES       3'h2
`define PREG_BYTES       3'h1
`define DATA_BYTES       3'h4
`define BANK_COUNT       10
`define BANK_W           4
`define BANK_PS          4'h0
`define BANK_TILE        4'h1
`define BANK_NODE        4'h2
`define BANK_PERIPH      4'h3

`endif

// file: rtl/cfg_bank.v
// One configuration register bank: an array of words with a write port
// and a registered read port. Assumes addresses come from the same clock.
`timescale 1ns/100ps
`default_nettype none
module cfg_bank #(
  parameter ADDR_W = 4
) (
  input  wire              clk_sys,
  input  wire              rst_n,
  input  wire              wr_en,
  input  wire [ADDR_W-1:0] addr,
  input  wire [31:0]       wdata,
  output reg  [31:0]       rdata
);
  reg [31:0] mem [0:(1<<ADDR_W)-1];
  integer    i;

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      for (i = 0; i < (1<<ADDR_W); i = i + 1) begin
        mem[i] <= 32'h0;
      end
      rdata <= 32'h0;
    end else begin
      if (wr_en) begin
        mem[addr] <= wdata;
      end
      rdata <= mem[addr];
    end
  end
endmodule
`default_nettype wire

// file: sim/cfg_access_assertions.sv
// Assertions on the request and answer token streams.
// Bound into every cfg_access instance.
`timescale 1ns/100ps
`default_nettype none
module cfg_access_assertions (
  input wire       clk_sys,
  input wire       rst_n,
  input wire       in_valid,
  input wire       in_ctrl,
  input wire [7:0] in_data,
  input wire       in_ready,
  input wire       out_valid,
  input wire       out_ctrl,
  input wire [7:0] out_data,
  input wire       out_ready
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire end_tk = in_valid && in_ready && in_ctrl && in_data == 8'h01;
  wire out_tk = out_valid && out_ready && out_ctrl;
  property p_hold; out_valid && !out_ready |=> out_valid && $stable({out_ctrl, out_data}); endproperty
  a_hold: assert property (p_hold) else $error("answer token changed early");
  property p_lat; end_tk |-> ##2 $rose(out_valid); endproperty
  a_lat: assert property (p_lat) else $error("answer late");
  property p_idle; end_tk |=> !in_ready && !out_valid; endproperty
  a_idle: assert property (p_idle) else $error("busy gap wrong");
  property p_first; $rose(out_valid) |-> out_ctrl && out_data inside {8'h03, 8'h04}; endproperty
  a_first: assert property (p_first) else $error("first answer token wrong");
  property p_nack; out_tk && out_data == 8'h04 |=> out_valid && out_ctrl && out_data == 8'h01; endproperty
  a_nack: assert property (p_nack) else $error("failure lacks closing token");
  property p_ctl; out_valid && out_ctrl |-> out_data inside {8'h01, 8'h03, 8'h04}; endproperty
  a_ctl: assert property (p_ctl) else $error("bad control token");
  property p_busy; out_valid |-> !in_ready; endproperty
  a_busy: assert property (p_busy) else $error("request taken while answering");
  property p_free; out_tk && out_data == 8'h01 |-> ##[1:3] in_ready; endproperty
  a_free: assert property (p_free) else $error("not ready after answer");
endmodule
bind cfg_access cfg_access_assertions cfg_access_assertions_inst (.clk_sys, .rst_n,
  .in_valid, .in_ctrl, .in_data, .in_ready, .out_valid, .out_ctrl, .out_data, .out_ready);
`default_nettype wire

// file: sim/cfg_access_tb.sv
// Self-checking bench: message and status accesses, answers via queue.
// Assumes 16 registers per bank and bank 3 as the peripheral bank.
`timescale 1ns/100ps
`default_nettype none
module cfg_access_tb;
  reg         clk_sys = 1'b0;
  reg         rst_n = 1'b0;
  reg  [15:0] ps_res_id = 16'h0000;
  reg         ps_rd = 1'b0;
  reg         ps_wr = 1'b0;
  reg  [31:0] ps_wdata = 32'h0;
  reg  [3:0]  msg_bank = 4'h0;
  reg         in_valid = 1'b0;
  reg         in_ctrl = 1'b0;
  reg  [7:0]  in_data = 8'h00;
  wire        in_ready, out_valid, out_ctrl, out_ready;
  wire [7:0]  out_data;
  wire [23:0] out_dest;
  wire [31:0] ps_rdata;
  integer     num_errors = 0;
  integer     cmp_count = 0;
  logic [32:0] exp_q[$];
  logic [31:0] mem [0:15][0:15];
  logic [7:0]  k;
  logic [15:0] r;
  logic [31:0] d;
  always #12.5 clk_sys = ~clk_sys;
  cfg_access #(.ADDR_W(4)) cfg_access_inst (.clk_sys, .rst_n, .ps_res_id, .ps_rd, .ps_wr,
    .ps_wdata, .ps_rdata, .msg_bank, .in_valid, .in_ctrl, .in_data, .in_ready,
    .out_valid, .out_ctrl, .out_data, .out_dest, .out_ready);
  resp_sink resp_sink_inst (.clk_sys, .rst_n, .out_ready);
  // ------
  // Shared tasks
  // ------
  task chk(input string n, input logic [32:0] s, input logic [32:0] e);
    cmp_count = cmp_count + 1;
    if (s !== e) begin
      num_errors = num_errors + 1;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task tok(input logic c, input logic [7:0] v);
    in_valid <= 1'b1;
    in_ctrl <= c;
    in_data <= v;
    @(posedge clk_sys);
    while (in_ready !== 1'b1) @(posedge clk_sys);
  endtask
  task msg(input logic [7:0] cmd, input logic [3:0] b, input logic [15:0] a,
           input logic [31:0] v, input logic ok);
    logic [23:0] ret;
    integer i, nr, nd;
    ret = $urandom;
    nr = cmd[7] ? 2 : 1;
    nd = cmd[0] ? 0 : 4;
    msg_bank <= b;
    tok(1'b1, cmd);
    for (i = 2; i >= 0; i--) tok(1'b0, ret[8*i+:8]);
    for (i = nr - 1; i >= 0; i--) tok(1'b0, a[8*i+:8]);
    if (nr == 1) tok(1'b0, 8'h04);
    for (i = nd - 1; i >= 0; i--) tok(1'b0, v[8*i+:8]);
    tok(1'b1, 8'h01);
    in_valid <= 1'b0;
    exp_q.push_back({ret, ok ? 9'h103 : 9'h104});
    if (ok && nd == 0) for (i = 3; i >= 0; i--) exp_q.push_back({ret, 1'b0, mem[b][a[3:0]][8*i+:8]});
    if (ok && nd != 0) mem[b][a[3:0]] = v;
    exp_q.push_back({ret, 9'h101});
    @(posedge clk_sys);
  endtask
  task drain(input string n);
    integer i;
    for (i = 0; i < 300 && exp_q.size() != 0; i++) @(posedge clk_sys);
    chk("pending answers", exp_q.size(), 33'h0);
    $display("test %s done", n);
  endtask
  task test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Answer monitor against the oldest note
  always @(posedge clk_sys) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      if (exp_q.size() == 0) chk("extra answer", 33'h1, 33'h0);
      else chk("answer", {out_dest, out_ctrl, out_data}, exp_q.pop_front());
    end
  end
  initial begin
    #(25 * 20000);
    num_errors = num_errors + 1;
    test_done;
  end
  initial begin
    $urandom(76577);
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    chk("idle after reset", {in_ready, out_valid}, 33'h2);
    for (k = 1; k < 10; k++) begin
      if (k == 3) continue;
      r = $urandom % 16;
      msg(8'hc0, k[3:0], r, $urandom, 1'b1);
      msg(8'hc1, k[3:0], r, 32'h0, 1'b1);
    end
    drain("banks");
    r = $urandom % 16;
    msg(8'h24, 4'h3, r, $urandom, 1'b1);
    msg(8'h25, 4'h3, r, 32'h0, 1'b1);
    drain("peripheral");
    msg(8'hc0, 4'h0, 16'h0001, $urandom, 1'b0);
    msg(8'hc1, 4'ha, 16'h0001, 32'h0, 1'b0);
    msg(8'hc1, 4'h1, 16'h0010, 32'h0, 1'b0);
    msg(8'hc3, 4'h1, 16'h0001, 32'h0, 1'b0);
    drain("failures");
    for (k = 0; k < 4; k++) begin
      d = $urandom;
      ps_res_id <= {k, 8'h0c};
      ps_wdata <= d;
      ps_wr <= 1'b1;
      @(posedge clk_sys);
      ps_wr <= 1'b0;
      ps_rd <= 1'b1;
      @(posedge clk_sys);
      ps_rd <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk("ps_rdata", ps_rdata, d);
    end
    $display("test status done");
    test_done;
  end
endmodule
`default_nettype wire

// file: sim/resp_sink.sv
// Far-side sink of the answer stream, stalling at random.
// Assumes the block holds each answer token until it is taken.
`timescale 1ns/100ps
`default_nettype none
module resp_sink (
  input  wire clk_sys,
  input  wire rst_n,
  output reg  out_ready = 1'b0
);
  // Sometimes prompt, sometimes several cycles slow
  always @(posedge clk_sys) begin
    out_ready <= rst_n && ($urandom % 3 != 0);
  end
endmodule
`default_nettype wire
